/* File: hdl/acs_pkg.sv */
package acs_pkg;
	// Register indices on the plain register port
	localparam logic [3:0] IDX_SEQ_CTRL = 4'h0;
	localparam logic [3:0] IDX_CLK_CFG = 4'h1;
	localparam logic [3:0] IDX_DMA_SIZE = 4'h2;
	localparam logic [3:0] IDX_AUX_SEL = 4'h3;
	localparam logic [3:0] IDX_PRIM_SEL = 4'h4;
	localparam logic [3:0] IDX_SCAN_HIGH = 4'h5;
	localparam logic [3:0] IDX_SCAN_LOW = 4'h6;
	localparam logic [3:0] IDX_PIN_HIGH = 4'h7;
	localparam logic [3:0] IDX_PIN_LOW = 4'h8;
	localparam logic [3:0] IDX_MODE_CTRL = 4'h9;

	// Writable bit masks, everything else reads zero except sequence_control bit 7, which reads the buffer half status
	localparam logic [15:0] MASK_SEQ_CTRL = 16'hE73F;
	localparam logic [15:0] MASK_CLK_CFG = 16'h9FFF;
	localparam logic [15:0] MASK_DMA_SIZE = 16'h0007;
	localparam logic [15:0] MASK_AUX_SEL = 16'h0707;
	localparam logic [15:0] MASK_PRIM_SEL = 16'h9F9F;
	localparam logic [15:0] MASK_FULL = 16'hFFFF;
	localparam logic [15:0] MASK_MODE_CTRL = 16'h001F;
	localparam logic [15:0] RESET_VALUE = 16'h0000;

	// Field positions in sequence_control
	localparam int POS_SCAN_EN = 10;
	localparam int POS_CHPS = 8;
	localparam int POS_BUF_HALF = 7;
	localparam int POS_SMPI = 2;
	localparam int POS_SPLIT = 1;
	localparam int POS_ALT = 0;
	// Field positions in conversion_clock_config
	localparam int POS_CLK_SRC = 15;
	localparam int POS_SAMC = 8;
	// Field positions in mode_control
	localparam int POS_ENABLE = 0;
	localparam int POS_RES_MODE = 1;
	localparam int POS_TRIG = 2;
	// Fields of the channel select registers
	localparam int POS_SET_B = 8;
	localparam int POS_AUX_NEG = 1;
	localparam int POS_PRIM_NEG = 7;

	localparam logic [2:0] TRIG_AUTO = 3'h7;
	localparam logic [5:0] CONV_TAD_10BIT = 6'h0C;
	localparam logic [5:0] CONV_TAD_12BIT = 6'h0E;

	typedef enum {ACS_IDLE, ACS_SAMPLE, ACS_CONVERT} acs_state_type;
endpackage

/* File: hdl/acs_top.sv */
`timescale 1ns/1ps
`default_nettype none
module acs_top #(
	parameter int NUM_INPUTS = 32,
	parameter bit SECOND_INSTANCE = 1'b0
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic [3:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [15:0] rdata_o,
	input wire logic trig_i,
	input wire logic rc_tick_i,
	input wire logic [15:0] other_pin_low_i,
	output logic sampling_o,
	output logic converting_o,
	output logic seq_done_o,
	output logic dma_step_o,
	output logic buf_half_o,
	output logic buf_restart_o,
	output logic use_set_b_o,
	output logic [3:0] chan_en_o,
	output logic [4:0] ch0_pos_o,
	output logic ch0_neg_an1_o,
	output logic ch0_neg_ref_o,
	output logic aux_pos_high_o,
	output logic [1:0] aux_neg_sel_o,
	output logic [7:0] words_per_input_o,
	output logic [31:0] digital_mode_o,
	output logic use_rc_clock_o
);
	// Elaboration check on the instance shape
	if (NUM_INPUTS < 1 || NUM_INPUTS > 32 || (SECOND_INSTANCE && NUM_INPUTS > 16)) begin : g_bad_shape
		$error("acs_top: NUM_INPUTS out of range for this instance");
	end

	logic [15:0] seq_ctrl, clk_cfg, dma_size, aux_sel, prim_sel;
	logic [15:0] scan_high, scan_low, pin_high, pin_low, mode_ctrl;
	acs_pkg::acs_state_type state, next_state;
	logic [7:0] tad_cnt;
	logic [4:0] samp_cnt;
	logic [5:0] conv_cnt;
	logic [3:0] seq_cnt;
	logic [4:0] scan_ptr;
	logic set_b;

	// Decoded fields
	wire res12 = mode_ctrl[acs_pkg::POS_RES_MODE];
	wire enable = mode_ctrl[acs_pkg::POS_ENABLE];
	wire [2:0] trig_src = mode_ctrl[acs_pkg::POS_TRIG +: 3];
	wire scan_en = seq_ctrl[acs_pkg::POS_SCAN_EN];
	wire [1:0] chps = seq_ctrl[acs_pkg::POS_CHPS +: 2];
	wire [3:0] smpi = seq_ctrl[acs_pkg::POS_SMPI +: 4];
	wire split_fill = seq_ctrl[acs_pkg::POS_SPLIT];
	wire alt_en = seq_ctrl[acs_pkg::POS_ALT];
	wire clk_src = clk_cfg[acs_pkg::POS_CLK_SRC];
	wire [4:0] samc = clk_cfg[acs_pkg::POS_SAMC +: 5];
	wire [7:0] divider = clk_cfg[7:0];
	wire [2:0] dma_k = dma_size[2:0];

	// Present inputs; the second instance never has the upper sixteen
	// Absent inputs on the first instance stay writable in the registers but are masked where they act
	localparam int EFF_INPUTS = SECOND_INSTANCE ? 16 : NUM_INPUTS;
	localparam logic [31:0] PRESENT = (EFF_INPUTS == 32) ? 32'hFFFFFFFF : ((32'h1 << EFF_INPUTS) - 32'h1);

	// Address decode; high registers vanish on the second instance
	// no high registers
	wire high_ok = !SECOND_INSTANCE;
	wire hit_seq = addr_i == acs_pkg::IDX_SEQ_CTRL;
	wire hit_clk = addr_i == acs_pkg::IDX_CLK_CFG;
	wire hit_dma = addr_i == acs_pkg::IDX_DMA_SIZE;
	wire hit_aux = addr_i == acs_pkg::IDX_AUX_SEL;
	wire hit_prim = addr_i == acs_pkg::IDX_PRIM_SEL;
	wire hit_sh = addr_i == acs_pkg::IDX_SCAN_HIGH && high_ok;
	wire hit_sl = addr_i == acs_pkg::IDX_SCAN_LOW;
	wire hit_ph = addr_i == acs_pkg::IDX_PIN_HIGH && high_ok;
	wire hit_pl = addr_i == acs_pkg::IDX_PIN_LOW;
	wire hit_mode = addr_i == acs_pkg::IDX_MODE_CTRL;

	// Read view: 12-bit mode hides the multi-channel fields
	// Stored values survive, so leaving 12-bit mode brings them back
	// hidden fields read zero
	wire [15:0] seq_view = {seq_ctrl[15:10], res12 ? 2'b00 : chps, buf_half_o, seq_ctrl[6:0]};
	wire [15:0] aux_view = res12 ? 16'h0000 : aux_sel;
	wire [15:0] read_mux = hit_seq ? seq_view :
		hit_clk ? clk_cfg :
		hit_dma ? dma_size :
		hit_aux ? aux_view :
		hit_prim ? prim_sel :
		hit_sh ? scan_high :
		hit_sl ? scan_low :
		hit_ph ? pin_high :
		hit_pl ? pin_low :
		hit_mode ? mode_ctrl : 16'h0000;

	// Register writes, masked to implemented bits
	// masked writes
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			seq_ctrl <= acs_pkg::RESET_VALUE;
			clk_cfg <= acs_pkg::RESET_VALUE;
			dma_size <= acs_pkg::RESET_VALUE;
			aux_sel <= acs_pkg::RESET_VALUE;
			prim_sel <= acs_pkg::RESET_VALUE;
			scan_high <= acs_pkg::RESET_VALUE;
			scan_low <= acs_pkg::RESET_VALUE;
			pin_high <= acs_pkg::RESET_VALUE;
			pin_low <= acs_pkg::RESET_VALUE;
			mode_ctrl <= acs_pkg::RESET_VALUE;
		end else if (wr_i) begin
			if (hit_seq) seq_ctrl <= wdata_i & acs_pkg::MASK_SEQ_CTRL;
			if (hit_clk) clk_cfg <= wdata_i & acs_pkg::MASK_CLK_CFG;
			if (hit_dma) dma_size <= wdata_i & acs_pkg::MASK_DMA_SIZE;
			if (hit_aux) aux_sel <= wdata_i & acs_pkg::MASK_AUX_SEL;
			if (hit_prim) prim_sel <= wdata_i & acs_pkg::MASK_PRIM_SEL;
			if (hit_sh) scan_high <= wdata_i & acs_pkg::MASK_FULL;
			if (hit_sl) scan_low <= wdata_i & acs_pkg::MASK_FULL;
			if (hit_ph) pin_high <= wdata_i & acs_pkg::MASK_FULL;
			if (hit_pl) pin_low <= wdata_i & acs_pkg::MASK_FULL;
			if (hit_mode) mode_ctrl <= wdata_i & acs_pkg::MASK_MODE_CTRL;
		end
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) rdata_o <= 16'h0000;
		else rdata_o <= rd_i ? read_mux : 16'h0000;
	end

	// Conversion clock tick: RC ticks arrive as a synchronous strobe
	// Divider runs free; conversion and auto sampling with nonzero samc end on a tick, external trigger and zero samc do not
	// clock source choice
	wire sys_tick = tad_cnt == divider;
	wire tad_tick = clk_src ? rc_tick_i : sys_tick;
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) tad_cnt <= 8'h00;
		else if (clk_src || sys_tick) tad_cnt <= 8'h00;
		else tad_cnt <= tad_cnt + 8'h01;
	end

	// Channels per sequence; 12-bit mode forces channel 0 alone
	// resolution picks channel count
	wire [3:0] next_chan_en = res12 ? 4'h1 : chps[1] ? 4'hF : chps[0] ? 4'h3 : 4'h1;
	wire [5:0] conv_unit = res12 ? acs_pkg::CONV_TAD_12BIT : acs_pkg::CONV_TAD_10BIT;
	wire [5:0] conv_len = chps[1] && !res12 ? 6'(conv_unit * 6'h4) :
		chps[0] && !res12 ? 6'(conv_unit * 6'h2) : conv_unit;

	// Sequencer: sampling restarts right after each conversion
	wire auto_trig = trig_src == acs_pkg::TRIG_AUTO;
	// sample length in conversion clocks
	// Ending on the last tick itself keeps the sample a whole number of clock periods
	wire samp_last = samc == 5'h00 || (tad_tick && samp_cnt == samc - 5'h01);
	wire samp_over = auto_trig ? samp_last : trig_i;
	wire conv_over = tad_tick && conv_cnt == conv_len - 6'h01;
	wire seq_end = state == acs_pkg::ACS_CONVERT && conv_over;
	always_comb begin
		next_state = state;
		case (state)
			acs_pkg::ACS_IDLE: if (enable) next_state = acs_pkg::ACS_SAMPLE;
			acs_pkg::ACS_SAMPLE: if (!enable) next_state = acs_pkg::ACS_IDLE;
				else if (samp_over) next_state = acs_pkg::ACS_CONVERT;
			acs_pkg::ACS_CONVERT: if (!enable) next_state = acs_pkg::ACS_IDLE;
				else if (conv_over) next_state = acs_pkg::ACS_SAMPLE;
			default: next_state = acs_pkg::ACS_IDLE;
		endcase
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state <= acs_pkg::ACS_IDLE;
			samp_cnt <= 5'h00;
			conv_cnt <= 6'h00;
		end else begin
			state <= next_state;
			samp_cnt <= (state != acs_pkg::ACS_SAMPLE || samp_over) ? 5'h00 :
				tad_tick ? samp_cnt + 5'h01 : samp_cnt;
			conv_cnt <= (state != acs_pkg::ACS_CONVERT || conv_over) ? 6'h00 :
				tad_tick ? conv_cnt + 6'h01 : conv_cnt;
		end
	end

	// Sequences per event
	// event every N+1 sequences
	wire event_hit = seq_end && seq_cnt == smpi;
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) seq_cnt <= 4'h0;
		else if (!enable || event_hit) seq_cnt <= 4'h0;
		else if (seq_end) seq_cnt <= seq_cnt + 4'h1;
	end

	// Buffer halves toggle at each event under split fill
	// Forcing the first half while split fill is off gives a clean start later
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			buf_half_o <= 1'b0;
			buf_restart_o <= 1'b0;
			dma_step_o <= 1'b0;
			seq_done_o <= 1'b0;
		end else begin
			// status shows the half being filled
			buf_half_o <= !split_fill ? 1'b0 : event_hit ? !buf_half_o : buf_half_o;
			buf_restart_o <= event_hit && !split_fill;
			dma_step_o <= event_hit;
			seq_done_o <= seq_end;
		end
	end

	// Input set alternation
	// set A/B alternation
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) set_b <= 1'b0;
		else if (!alt_en || !enable) set_b <= 1'b0;
		else if (seq_end) set_b <= !set_b;
	end

	// Next scan-selected input after a position, wrapping round
	function automatic logic [4:0] acs_next_scan(input logic [31:0] m, input logic [4:0] p);
		logic [4:0] r;
		logic found;
		logic [4:0] idx;
		r = p;
		found = 1'b0;
		for (int i = 1; i <= 32; i++) begin
			idx = 5'(p + 5'(i));
			if (!found && m[idx]) begin
				r = idx;
				found = 1'b1;
			end
		end
		return r;
	endfunction

	wire [31:0] scan_mask = {high_ok ? scan_high : 16'h0000, scan_low};
	wire [4:0] scan_cur = scan_mask[scan_ptr] ? scan_ptr : acs_next_scan(scan_mask, scan_ptr);
	// scan only on set A with scan enabled
	wire scanning = scan_en && !set_b && scan_mask != 32'h0;
	// Pointer survives a converter disable, but clearing scan_en sends it back to input 0
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) scan_ptr <= 5'h00;
		else if (!scan_en) scan_ptr <= 5'h00;
		else if (seq_end && !set_b) scan_ptr <= acs_next_scan(scan_mask, scan_cur);
	end

	// Multiplexer selection for the active input set
	// channel 0 positive field
	wire [4:0] prim_pos = set_b ? prim_sel[12:8] : prim_sel[4:0];
	wire [4:0] next_ch0_pos = scanning ? scan_cur : prim_pos;
	wire next_ch0_neg = set_b ? prim_sel[acs_pkg::POS_PRIM_NEG + acs_pkg::POS_SET_B] :
		prim_sel[acs_pkg::POS_PRIM_NEG];
	wire next_aux_pos = res12 ? 1'b0 : set_b ? aux_sel[acs_pkg::POS_SET_B] : aux_sel[0];
	// aux negative code, 0x means low reference
	wire [1:0] aux_neg_raw = set_b ? aux_sel[acs_pkg::POS_AUX_NEG + acs_pkg::POS_SET_B +: 2] :
		aux_sel[acs_pkg::POS_AUX_NEG +: 2];
	wire [1:0] next_aux_neg = (res12 || !aux_neg_raw[1]) ? 2'b00 : aux_neg_raw;
	// absent input converts the negative reference
	wire next_neg_ref = !PRESENT[next_ch0_pos];
	// digital mode grounds the mux input
	// shared low pins follow either converter
	wire [31:0] next_digital = ({high_ok ? pin_high : 16'h0000, pin_low | other_pin_low_i}) & PRESENT;
	wire [7:0] next_words = 8'(8'h01 << dma_k);

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			chan_en_o <= 4'h1;
			ch0_pos_o <= 5'h00;
			ch0_neg_an1_o <= 1'b0;
			ch0_neg_ref_o <= 1'b0;
			aux_pos_high_o <= 1'b0;
			aux_neg_sel_o <= 2'b00;
			words_per_input_o <= 8'h01;
			digital_mode_o <= 32'h00000000;
			use_rc_clock_o <= 1'b0;
			use_set_b_o <= 1'b0;
			sampling_o <= 1'b0;
			converting_o <= 1'b0;
		end else begin
			chan_en_o <= next_chan_en;
			ch0_pos_o <= next_ch0_pos;
			ch0_neg_an1_o <= next_ch0_neg;
			ch0_neg_ref_o <= next_neg_ref;
			aux_pos_high_o <= next_aux_pos;
			aux_neg_sel_o <= next_aux_neg;
			words_per_input_o <= next_words;
			digital_mode_o <= next_digital;
			use_rc_clock_o <= clk_src;
			use_set_b_o <= set_b;
			sampling_o <= next_state == acs_pkg::ACS_SAMPLE;
			converting_o <= next_state == acs_pkg::ACS_CONVERT;
		end
	end

	// Sequences seen since the last event, for checking only
	logic [4:0] chk_seqs;
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) chk_seqs <= 5'h00;
		else if (!enable || event_hit) chk_seqs <= 5'h00;
		else if (seq_end) chk_seqs <= chk_seqs + 5'h01;
	end

	a_event_rate: assert property (@(posedge clk_i) disable iff (!nrst_i)
		event_hit |-> chk_seqs == {1'b0, smpi})
		else $error("event not after N+1 sequences");
	a_chan_count: assert property (@(posedge clk_i) disable iff (!nrst_i)
		##1 !$past(res12) && $past(chps) == 2'b01 |-> chan_en_o == 4'h3)
		else $error("channels 0 and 1 not selected");
	a_hidden_read: assert property (@(posedge clk_i) disable iff (!nrst_i)
		rd_i && hit_aux && res12 |=> rdata_o == 16'h0000)
		else $error("aux select visible in 12-bit mode");
	a_half_toggle: assert property (@(posedge clk_i) disable iff (!nrst_i)
		event_hit && split_fill |=> buf_half_o != $past(buf_half_o))
		else $error("buffer half did not alternate");
	a_half_plain: assert property (@(posedge clk_i) disable iff (!nrst_i)
		!split_fill |=> !buf_half_o ##0 (buf_restart_o == $past(event_hit)))
		else $error("plain fill not restarting at start");
	a_set_a_only: assert property (@(posedge clk_i) disable iff (!nrst_i)
		!alt_en |=> !set_b ##1 !use_set_b_o)
		else $error("set B used without alternation");
	a_tad_divide: assert property (@(posedge clk_i) disable iff (!nrst_i)
		!clk_src |=> tad_cnt == ($past(sys_tick) ? 8'h00 : 8'($past(tad_cnt) + 8'h01)))
		else $error("conversion clock divider count wrong");
	a_sample_len: assert property (@(posedge clk_i) disable iff (!nrst_i)
		state == acs_pkg::ACS_SAMPLE && auto_trig && enable && tad_tick && samp_cnt == samc - 5'h01
		|=> state == acs_pkg::ACS_CONVERT)
		else $error("auto sample did not end on time");
	a_words_pow: assert property (@(posedge clk_i) disable iff (!nrst_i)
		dma_k == 3'h7 && $stable(dma_k) |=> words_per_input_o == 8'h80)
		else $error("buffer words wrong");
	a_scan_off: assert property (@(posedge clk_i) disable iff (!nrst_i)
		!scan_en && !set_b |=> ch0_pos_o == $past(prim_sel[4:0]))
		else $error("channel 0 moved without scan");
	a_absent_pin: assert property (@(posedge clk_i) disable iff (!nrst_i)
		##1 ((digital_mode_o & ~PRESENT) == 32'h0))
		else $error("absent pin took effect");
endmodule
`default_nettype wire

/* File: hdl/acs_top_dummy_guard.sv */
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

/* File: verification/acs_far_side.sv */
`timescale 1ns/1ps
`default_nettype none
// Analog front end stand-in: RC oscillator ticks and an external trigger
module acs_far_side #(
	parameter int RC_DIV = 3,
	parameter int TRIG_WAIT = 4
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic sampling_i,
	output logic rc_tick_o,
	output logic trig_o
);
	int rc_cnt;
	int smp_cnt;
	// Oscillator runs free, so its phase is unrelated to sequence starts
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rc_cnt <= 0;
			rc_tick_o <= 1'b0;
		end else begin
			rc_cnt <= (rc_cnt == RC_DIV - 1) ? 0 : rc_cnt + 1;
			rc_tick_o <= (rc_cnt == RC_DIV - 1);
		end
	end
	// Trigger pulses once per sampling window, never while holding
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			smp_cnt <= 0;
			trig_o <= 1'b0;
		end else begin
			smp_cnt <= sampling_i ? smp_cnt + 1 : 0;
			trig_o <= sampling_i && (smp_cnt == TRIG_WAIT);
		end
	end
endmodule
`default_nettype wire

/* File: verification/acs_top_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module acs_top_bench;
	localparam int NIN = 20;
	logic clk_i, nrst_i, wr_i, rd_i, trig_i, rc_tick_i;
	logic [3:0] addr_i;
	logic [15:0] wdata_i, rdata_o, other_pin_low_i, rv;
	logic sampling_o, converting_o, seq_done_o, dma_step_o, buf_half_o, buf_restart_o, use_set_b_o;
	logic ch0_neg_an1_o, ch0_neg_ref_o, aux_pos_high_o, use_rc_clock_o, b_at, h0, r1, r2;
	logic [3:0] chan_en_o;
	logic [4:0] ch0_pos_o, pos_at;
	logic [1:0] aux_neg_sel_o;
	logic [7:0] words_per_input_o;
	logic [31:0] digital_mode_o;
	logic [15:0] mreg [16];
	int n_errors, n_checks, a, b, c, sl, n1, n2;

	acs_top #(.NUM_INPUTS(NIN), .SECOND_INSTANCE(1'b0)) uut (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .trig_i(trig_i), .rc_tick_i(rc_tick_i),
		.other_pin_low_i(other_pin_low_i), .sampling_o(sampling_o), .converting_o(converting_o),
		.seq_done_o(seq_done_o), .dma_step_o(dma_step_o), .buf_half_o(buf_half_o), .buf_restart_o(buf_restart_o),
		.use_set_b_o(use_set_b_o), .chan_en_o(chan_en_o), .ch0_pos_o(ch0_pos_o), .ch0_neg_an1_o(ch0_neg_an1_o),
		.ch0_neg_ref_o(ch0_neg_ref_o), .aux_pos_high_o(aux_pos_high_o), .aux_neg_sel_o(aux_neg_sel_o),
		.words_per_input_o(words_per_input_o), .digital_mode_o(digital_mode_o), .use_rc_clock_o(use_rc_clock_o));
	acs_far_side #(.RC_DIV(3), .TRIG_WAIT(4)) far (.clk_i(clk_i), .nrst_i(nrst_i),
		.sampling_i(sampling_o), .rc_tick_o(rc_tick_i), .trig_o(trig_i));

	// Clock
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end

	// Writable bits per register index, unmapped ones hold nothing
	function automatic logic [15:0] wmask(input int i);
		case (i)
			0: return 16'hE73F;
			1: return 16'h9FFF;
			2: return 16'h0007;
			3: return 16'h0707;
			4: return 16'h9F9F;
			5, 6, 7, 8: return 16'hFFFF;
			9: return 16'h001F;
			default: return 16'h0000;
		endcase
	endfunction

	task wrap_up;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task give_up;
		n_errors++;
		$display("MISMATCH t=%0t wait limit ran out", $time);
		wrap_up;
	endtask

	task tk;
		@(posedge clk_i);
		#1;
	endtask

	task wr(input int i, input logic [15:0] d);
		@(posedge clk_i);
		addr_i <= i[3:0];
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
		mreg[i] = d & wmask(i);
	endtask

	// Read data stand only in the cycle after the strobe
	task rd(input int i, output logic [15:0] d);
		@(posedge clk_i);
		addr_i <= i[3:0];
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 d = rdata_o;
	endtask

	// Length of the next sampling or converting window, input mux noted at its start
	task hi_len(input bit cv, output int n);
		int k;
		k = 0;
		n = 0;
		while ((cv ? converting_o : sampling_o) !== 1'b1 && k < 3000) begin
			tk;
			k++;
		end
		if (k >= 3000) give_up;
		pos_at = ch0_pos_o;
		b_at = use_set_b_o;
		while ((cv ? converting_o : sampling_o) === 1'b1 && n < 3000) begin
			tk;
			n++;
		end
	endtask

	// Sequences seen up to and including the next DMA step
	task step_gap(output int n, output logic r);
		int k;
		k = 0;
		n = 0;
		r = 1'b0;
		while (k < 5000) begin
			tk;
			k++;
			n += (seq_done_o === 1'b1);
			if (dma_step_o === 1'b1) break;
		end
		if (k >= 5000) give_up;
		r = buf_restart_o;
		tk;
		tk;
	endtask

	initial begin
		nrst_i = 1'b0;
		wr_i = 1'b0;
		rd_i = 1'b0;
		addr_i = 4'h0;
		wdata_i = 16'h0000;
		other_pin_low_i = 16'h0000;
		n_errors = 0;
		n_checks = 0;
		for (a = 0; a < 16; a++) mreg[a] = 16'h0000;
		void'($urandom(32'h1049));
		repeat (16) @(posedge clk_i);
		nrst_i <= 1'b1;
		for (a = 0; a < 10; a++) begin
			rd(a, rv);
			chk(rv, 0);
		end
		chk(chan_en_o, 1);
		chk(words_per_input_o, 1);
		// Random register contents, decoded selections while idle
		repeat (4) begin
			for (a = 0; a < 16; a++) wr(a, (a == 9) ? 16'($urandom) & 16'hFFE0 : 16'($urandom));
			wr(0, mreg[0] & 16'hFBFF);
			other_pin_low_i <= 16'($urandom);
			for (a = 0; a < 16; a++) begin
				rd(a, rv);
				chk(rv, mreg[a]);
			end
			tk;
			chk(ch0_pos_o, mreg[4][4:0]);
			chk(ch0_neg_an1_o, mreg[4][7]);
			chk(ch0_neg_ref_o, mreg[4][4:0] >= NIN);
			chk(aux_pos_high_o, mreg[3][0]);
			chk(aux_neg_sel_o, mreg[3][2] ? mreg[3][2:1] : 2'b00);
			chk(words_per_input_o, 1 << mreg[2][2:0]);
			chk(use_rc_clock_o, mreg[1][15]);
			chk(chan_en_o, mreg[0][9] ? 15 : mreg[0][8] ? 3 : 1);
			chk(digital_mode_o, {mreg[7], mreg[8] | other_pin_low_i} & ((32'h1 << NIN) - 1));
		end
		// Narrow fields vanish in 12-bit mode
		wr(9, 16'h0002);
		rd(0, rv);
		chk(rv, mreg[0] & 16'hFCFF);
		rd(3, rv);
		chk(rv, 0);
		tk;
		chk(chan_en_o, 1);
		chk(aux_pos_high_o, 0);
		wr(9, 16'h0000);
		// Sample and conversion lengths: divider 2, RC clock, external trigger
		for (c = 0; c < 7; c++) begin
			wr(1, {c == 5, 2'h0, 5'(2 + c), 8'h02});
			wr(0, {6'h00, 2'(c), 8'h00});
			wr(9, {11'h000, (c == 6) ? 3'h0 : 3'h7, c == 4, 1'h1});
			hi_len(1, a);
			hi_len(0, sl);
			hi_len(1, a);
			if (c == 0) b = sl;
			if (c < 5) chk(sl - b, c * 3);
			chk(a, (c == 4 ? 14 : 12) * 3 * (c == 4 ? 1 : c[1] ? 4 : c[0] ? 2 : 1));
			wr(9, 16'h0000);
		end
		// Event rate and buffer halves over the four fill/alternate settings
		for (c = 0; c < 4; c++) begin
			a = $urandom_range(15);
			wr(1, 16'h0100);
			wr(0, {10'h000, 4'(a), 1'(c), 1'(c >> 1)});
			wr(9, 16'h001D);
			step_gap(n1, r1);
			h0 = buf_half_o;
			step_gap(n2, r2);
			chk(n1, a + 1);
			chk(n2, a + 1);
			chk(r2, !c[0]);
			chk(h0, c[0]);
			chk(buf_half_o, 1'b0);
			wr(9, 16'h0000);
		end
		// Scan over inputs 3 and 7 in set A, set B fixed on input 9
		wr(4, 16'h0900);
		wr(5, 16'h0000);
		wr(6, 16'h0088);
		for (c = 0; c < 2; c++) begin
			wr(0, {5'h00, 1'h1, 9'h000, 1'(c)});
			wr(9, 16'h001D);
			b = 0;
			for (a = 0; a < 5; a++) begin
				hi_len(1, sl);
				chk(b_at, c && a[0]);
				chk(pos_at, (c && a[0]) ? 9 : b ? 7 : 3);
				if (!(c && a[0])) b = !b;
			end
			wr(9, 16'h0000);
			wr(0, 16'h0000);
		end
		wrap_up;
	end
endmodule
`default_nettype wire
